// file: core/osdw_pkg.sv
// Constants, header layout and types for the OSD region walker
package osdw_pkg;

	// Register port map
	localparam int ADDR_W = 8;
	localparam logic [7:0] CFG_OFS = 8'h00;
	localparam logic [7:0] FSA_OFS = 8'h04;
	localparam logic [7:0] STAT_OFS = 8'h08;

	// overlay_config_reg fields
	localparam int CFG_ON_BIT = 0;
	localparam int CFG_SMOOTH_OFF_BIT = 1;
	localparam int CFG_PROG_BIT = 2;
	localparam int CFG_SMOOTH_LSB = 8;
	localparam logic [31:0] CFG_RESET = 32'h0000_0002;
	localparam logic [31:0] FSA_RESET = 32'h0000_0000;

	// Status fields
	localparam int STAT_ON_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	localparam int STAT_ROW_LSB = 16;

	// Header word indices
	localparam int HDR_WORDS = 9;
	localparam int HW_CTRL = 0;
	localparam int HW_PAL = 1;
	localparam int HW_TOTAL = 2;
	localparam int HW_BOTLEFT = 3;
	localparam int HW_TOPRIGHT = 4;
	localparam int HW_BOTP = 5;
	localparam int HW_TOPP = 6;
	localparam int HW_PALP = 7;
	localparam int HW_NEXTP = 8;

	// Header field positions
	localparam int NP_BIT = 0;
	localparam int SLL_BIT = 1;
	localparam int FM_LSB = 3;
	localparam int BLEND_SELECT_LSB = 5;
	localparam int LINE_PIXEL_COUNT_LSB = 16;
	localparam int CIDX_LSB = 0;
	localparam int NCL_LSB = 8;
	localparam int PITCH_LSB = 16;
	localparam int FIELD_PIXEL_TOTAL_LSB = 0;
	localparam int XPOS_LSB = 0;
	localparam int YPOS_LSB = 12;

	// Addressing
	localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
	localparam logic [12:0] PIX_ROUND = 13'h0003;
	localparam int LBUF_AW = 10;
	localparam logic [11:0] ONE_12 = 12'h001;

	// Blend modes
	localparam logic [1:0] BLEND_PIXEL = 2'h0;
	localparam logic [1:0] BLEND_GLOBAL = 2'h1;
	localparam logic [1:0] BLEND_PROP = 2'h2;
	localparam logic [1:0] BLEND_NONE = 2'h3;

	// Vertical filter modes
	localparam logic [1:0] FILT_OFF = 2'h0;
	localparam logic [1:0] FILT_FLICKER = 2'h1;
	localparam logic [1:0] FILT_FLUTTER = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_HDR,
		ST_PAL,
		ST_WAIT,
		ST_LINE,
		ST_SHOW,
		ST_DONE
	} osdw_state_t;

endpackage

// file: core/osdw_walker.sv
// OSD region walker: header chain, palette load, line fetch and pixel output
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Contract
// (RULE_01) Palette fetch starts at palette pointer
// (RULE_02) Software sets new-palette flag when needed
// (RULE_03) Bitmap fetch starts at field pointer
// (RULE_04) Same top and bottom pointers accepted
// (RULE_05) Next header from next-spec pointer
// (RULE_06) Software marks final region list end
// (RULE_07) Region starts at top line, at least 3
// (RULE_08) Region ends at bottom line
// (RULE_09) Region starts at left pixel position
// (RULE_10) Region ends at right pixel position
// (RULE_11) Same TV lines interlaced and progressive
// (RULE_12) Progressive shows twice line difference
// (RULE_13) Interlaced shows difference lines per field
// (RULE_14) Total pixels per field limit
// (RULE_15) Pointer advances by pitch per line
// (RULE_16) Same pixel count every line
// (RULE_17) Palette written from load index
// (RULE_18) Colour count is field plus one
// (RULE_19) Unloaded table entries are kept
// (RULE_20) Four blend modes per region
// (RULE_21) Filter select applied to table values
// (RULE_22) Flicker and flutter never together
// (RULE_23) Edge smoothing on first/last lines only
// (RULE_24) Blend field decode 00 01 10 11
// (RULE_25) Filter field decode, 11 reserved
// (RULE_26) Stop after list end region
// (RULE_27) Software leaves blank line between regions
// (RULE_28) No overlay outside region or after end
// (RULE_29) Header and palette ready before first line
module osdw_walker (
	input wire logic CLK_IN,
	input wire logic ARST_N_IN,
	input wire logic [7:0] ADDR_IN,
	input wire logic [31:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	output logic [31:0] RDATA_OUT,
	output logic MEM_REQ_OUT,
	output logic [31:0] MEM_ADDR_OUT,
	input wire logic MEM_ACK_IN,
	input wire logic [31:0] MEM_RDATA_IN,
	input wire logic FIELD_START_IN,
	input wire logic FIELD_BOTTOM_IN,
	input wire logic LINE_START_IN,
	input wire logic [11:0] LINE_NUM_IN,
	input wire logic PIX_EN_IN,
	input wire logic [11:0] PIXEL_X_IN,
	output logic OSD_VALID_OUT,
	output logic [31:0] OSD_COLOUR_OUT,
	output logic [1:0] BLEND_SELECT_OUT,
	output logic FLICKER_ON_OUT,
	output logic FLUTTER_ON_OUT,
	output logic EDGE_SMOOTH_ON_OUT,
	output logic [7:0] EDGE_SMOOTH_VALUE_OUT
);

	////////////////////////////////////////////////////////////////////////
	// Storage and state

	logic [31:0] cfg_reg;
	logic [31:0] fsa_reg;
	logic [31:0] rdata_reg;
	osdw_pkg::osdw_state_t state_reg;
	logic [31:0] mem_addr_reg;
	logic [10:0] cnt_reg;
	logic [31:0] line_ptr_reg;
	logic [11:0] fill_row_reg;
	logic field_bottom_reg;
	logic region_on_reg;
	logic [11:0] disp_row_reg;
	logic [21:0] total_left_reg;
	logic valid_reg;
	logic [31:0] colour_reg;
	logic [1:0] blend_reg;
	logic flicker_reg;
	logic flutter_reg;
	logic edge_reg;

	logic [31:0] hdr_mem [0:osdw_pkg::HDR_WORDS-1];
	logic [31:0] clut_mem [0:255];
	logic [31:0] lbuf_mem [0:(2 << osdw_pkg::LBUF_AW)-1];

	////////////////////////////////////////////////////////////////////////
	// Header fields

	logic new_palette_flag;
	logic list_end_flag;
	logic [1:0] vfilter_select;
	logic [1:0] blend_select;
	logic [11:0] line_pixel_count;
	logic [7:0] table_load_index;
	logic [7:0] colour_load_count;
	logic [12:0] pitch;
	logic [21:0] field_pixel_total;
	logic [10:0] y_top;
	logic [10:0] y_bottom;
	logic [11:0] x_left;
	logic [11:0] x_right;
	logic [10:0] y_diff;
	logic [11:0] start_line;
	logic [11:0] row_total;
	logic [12:0] pix_round;
	logic [10:0] line_words;
	logic [31:0] field_ptr;
	logic progressive;
	logic edge_smooth_disable;
	logic [7:0] edge_smooth_value;

	assign new_palette_flag = hdr_mem[osdw_pkg::HW_CTRL][osdw_pkg::NP_BIT];
	assign list_end_flag = hdr_mem[osdw_pkg::HW_CTRL][osdw_pkg::SLL_BIT];
	assign vfilter_select = hdr_mem[osdw_pkg::HW_CTRL][osdw_pkg::FM_LSB +: 2];
	assign blend_select = hdr_mem[osdw_pkg::HW_CTRL][osdw_pkg::BLEND_SELECT_LSB +: 2];
	assign line_pixel_count = hdr_mem[osdw_pkg::HW_CTRL][osdw_pkg::LINE_PIXEL_COUNT_LSB +: 12];
	assign table_load_index = hdr_mem[osdw_pkg::HW_PAL][osdw_pkg::CIDX_LSB +: 8];
	assign colour_load_count = hdr_mem[osdw_pkg::HW_PAL][osdw_pkg::NCL_LSB +: 8];
	assign pitch = hdr_mem[osdw_pkg::HW_PAL][osdw_pkg::PITCH_LSB +: 13];
	assign field_pixel_total = hdr_mem[osdw_pkg::HW_TOTAL][osdw_pkg::FIELD_PIXEL_TOTAL_LSB +: 22];
	assign y_bottom = hdr_mem[osdw_pkg::HW_BOTLEFT][osdw_pkg::YPOS_LSB +: 11];
	assign x_left = hdr_mem[osdw_pkg::HW_BOTLEFT][osdw_pkg::XPOS_LSB +: 12];
	assign y_top = hdr_mem[osdw_pkg::HW_TOPRIGHT][osdw_pkg::YPOS_LSB +: 11];
	assign x_right = hdr_mem[osdw_pkg::HW_TOPRIGHT][osdw_pkg::XPOS_LSB +: 12];

	assign progressive = cfg_reg[osdw_pkg::CFG_PROG_BIT];
	assign edge_smooth_disable = cfg_reg[osdw_pkg::CFG_SMOOTH_OFF_BIT];
	assign edge_smooth_value = cfg_reg[osdw_pkg::CFG_SMOOTH_LSB +: 8];

	// Field line numbers double on a progressive raster
	assign y_diff = y_bottom - y_top;  // [RULE_08]
	assign start_line = progressive ? {y_top, 1'b0} : {1'b0, y_top};  // [RULE_07] [RULE_11]
	assign row_total = progressive ? {y_diff, 1'b0} : {1'b0, y_diff};  // [RULE_12] [RULE_13]

	// Whole words per line, rounded up
	assign pix_round = {1'b0, line_pixel_count} + osdw_pkg::PIX_ROUND;
	assign line_words = pix_round[12:2];  // [RULE_16]

	// Progressive output scans the top block only
	assign field_ptr = (field_bottom_reg && !progressive) ? hdr_mem[osdw_pkg::HW_BOTP]
		: hdr_mem[osdw_pkg::HW_TOPP];  // [RULE_03] [RULE_04]

	////////////////////////////////////////////////////////////////////////
	// Register port

	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			cfg_reg <= osdw_pkg::CFG_RESET;
			fsa_reg <= osdw_pkg::FSA_RESET;
		end else if (WR_IN) begin
			if (ADDR_IN == osdw_pkg::CFG_OFS) begin
				cfg_reg <= WDATA_IN;
			end
			if (ADDR_IN == osdw_pkg::FSA_OFS) begin
				fsa_reg <= WDATA_IN;
			end
		end
	end

	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			rdata_reg <= '0;
		end else begin
			rdata_reg <= '0;
			if (RD_IN) begin
				unique case (ADDR_IN)
					osdw_pkg::CFG_OFS: rdata_reg <= cfg_reg;
					osdw_pkg::FSA_OFS: rdata_reg <= fsa_reg;
					osdw_pkg::STAT_OFS: begin
						rdata_reg[osdw_pkg::STAT_ON_BIT] <= region_on_reg;
						rdata_reg[osdw_pkg::STAT_DONE_BIT] <= (state_reg == osdw_pkg::ST_DONE);
						rdata_reg[osdw_pkg::STAT_ROW_LSB +: 12] <= disp_row_reg;
					end
					default: rdata_reg <= '0;
				endcase
			end
		end
	end

	assign RDATA_OUT = rdata_reg;

	////////////////////////////////////////////////////////////////////////
	// Walker state machine and memory requests

	logic region_last_line;
	assign region_last_line = region_on_reg && (disp_row_reg + osdw_pkg::ONE_12 == row_total);

	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			state_reg <= osdw_pkg::ST_IDLE;
			mem_addr_reg <= '0;
			cnt_reg <= '0;
			line_ptr_reg <= '0;
			fill_row_reg <= '0;
			field_bottom_reg <= 1'b0;
		end else if (FIELD_START_IN) begin
			field_bottom_reg <= FIELD_BOTTOM_IN;
			cnt_reg <= '0;
			mem_addr_reg <= fsa_reg;
			state_reg <= cfg_reg[osdw_pkg::CFG_ON_BIT] ? osdw_pkg::ST_HDR : osdw_pkg::ST_IDLE;
		end else begin
			unique case (state_reg)
				osdw_pkg::ST_IDLE: begin
				end
				osdw_pkg::ST_HDR: begin
					if (MEM_ACK_IN) begin
						if (cnt_reg == 11'(osdw_pkg::HDR_WORDS - 1)) begin
							cnt_reg <= '0;
							if (new_palette_flag) begin
								mem_addr_reg <= hdr_mem[osdw_pkg::HW_PALP];  // [RULE_01]
								state_reg <= osdw_pkg::ST_PAL;
							end else begin
								state_reg <= osdw_pkg::ST_WAIT;  // [RULE_19]
							end
						end else begin
							cnt_reg <= cnt_reg + 11'h001;
							mem_addr_reg <= mem_addr_reg + osdw_pkg::WORD_BYTES;
						end
					end
				end
				osdw_pkg::ST_PAL: begin
					if (MEM_ACK_IN) begin
						if (cnt_reg[7:0] == colour_load_count) begin  // [RULE_18]
							cnt_reg <= '0;
							state_reg <= osdw_pkg::ST_WAIT;
						end else begin
							cnt_reg <= cnt_reg + 11'h001;
							mem_addr_reg <= mem_addr_reg + osdw_pkg::WORD_BYTES;
						end
					end
				end
				osdw_pkg::ST_WAIT: begin
					// Row 0 is fetched on the line before the region opens
					if (LINE_START_IN && (LINE_NUM_IN + osdw_pkg::ONE_12 == start_line)) begin  // [RULE_29]
						cnt_reg <= '0;
						fill_row_reg <= '0;
						mem_addr_reg <= field_ptr;  // [RULE_03]
						line_ptr_reg <= field_ptr;
						if (row_total == '0) begin
							mem_addr_reg <= hdr_mem[osdw_pkg::HW_NEXTP];
							state_reg <= list_end_flag ? osdw_pkg::ST_DONE : osdw_pkg::ST_HDR;
						end else if (line_words == '0) begin
							fill_row_reg <= osdw_pkg::ONE_12;
							state_reg <= osdw_pkg::ST_SHOW;
						end else begin
							state_reg <= osdw_pkg::ST_LINE;
						end
					end
				end
				osdw_pkg::ST_LINE: begin
					if (MEM_ACK_IN) begin
						if (cnt_reg == line_words - 11'h001) begin
							cnt_reg <= '0;
							fill_row_reg <= fill_row_reg + osdw_pkg::ONE_12;
							line_ptr_reg <= line_ptr_reg + {19'h00000, pitch};  // [RULE_15]
							state_reg <= osdw_pkg::ST_SHOW;
						end else begin
							cnt_reg <= cnt_reg + 11'h001;
							mem_addr_reg <= mem_addr_reg + osdw_pkg::WORD_BYTES;
						end
					end
				end
				osdw_pkg::ST_SHOW: begin
					if (LINE_START_IN) begin
						if (region_last_line) begin
							cnt_reg <= '0;
							mem_addr_reg <= hdr_mem[osdw_pkg::HW_NEXTP];  // [RULE_05]
							state_reg <= list_end_flag ? osdw_pkg::ST_DONE : osdw_pkg::ST_HDR;  // [RULE_26]
						end else if (fill_row_reg < row_total) begin
							cnt_reg <= '0;
							mem_addr_reg <= line_ptr_reg;
							if (line_words == '0) begin
								fill_row_reg <= fill_row_reg + osdw_pkg::ONE_12;
							end else begin
								state_reg <= osdw_pkg::ST_LINE;
							end
						end
					end
				end
				osdw_pkg::ST_DONE: begin
				end
			endcase
		end
	end

	assign MEM_REQ_OUT = (state_reg == osdw_pkg::ST_HDR) || (state_reg == osdw_pkg::ST_PAL)
		|| (state_reg == osdw_pkg::ST_LINE);
	assign MEM_ADDR_OUT = mem_addr_reg;

	////////////////////////////////////////////////////////////////////////
	// Header, colour table and line buffer writes

	always_ff @(posedge CLK_IN) begin
		if (state_reg == osdw_pkg::ST_HDR && MEM_ACK_IN && !FIELD_START_IN) begin
			hdr_mem[cnt_reg[3:0]] <= MEM_RDATA_IN;
		end
	end

	logic [7:0] clut_wr_idx;
	assign clut_wr_idx = table_load_index + cnt_reg[7:0];

	// Only the addressed entries change
	always_ff @(posedge CLK_IN) begin
		if (state_reg == osdw_pkg::ST_PAL && MEM_ACK_IN && !FIELD_START_IN) begin
			clut_mem[clut_wr_idx] <= MEM_RDATA_IN;  // [RULE_17] [RULE_19]
		end
	end

	// Halves alternate by row parity
	always_ff @(posedge CLK_IN) begin
		if (state_reg == osdw_pkg::ST_LINE && MEM_ACK_IN && !FIELD_START_IN) begin
			lbuf_mem[{fill_row_reg[0], cnt_reg[osdw_pkg::LBUF_AW-1:0]}] <= MEM_RDATA_IN;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Region rows and pixel output

	logic row_open;
	logic [11:0] pix_idx;
	logic in_window;
	logic [31:0] pix_word;
	logic [7:0] pix_byte;
	logic edge_row;

	assign row_open = (state_reg == osdw_pkg::ST_LINE || state_reg == osdw_pkg::ST_SHOW)
		&& (LINE_NUM_IN == start_line);
	assign pix_idx = PIXEL_X_IN - x_left;
	assign in_window = region_on_reg && cfg_reg[osdw_pkg::CFG_ON_BIT]  // [RULE_28]
		&& (PIXEL_X_IN >= x_left) && (PIXEL_X_IN < x_right)
		&& (pix_idx < line_pixel_count) && (total_left_reg != '0);  // [RULE_09] [RULE_10] [RULE_14] [RULE_16]
	assign pix_word = lbuf_mem[{disp_row_reg[0], pix_idx[osdw_pkg::LBUF_AW+1:2]}];
	assign pix_byte = pix_word[{pix_idx[1:0], 3'h0} +: 8];
	assign edge_row = (disp_row_reg == '0) || (disp_row_reg + osdw_pkg::ONE_12 == row_total);

	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			region_on_reg <= 1'b0;
			disp_row_reg <= '0;
			total_left_reg <= '0;
		end else if (FIELD_START_IN) begin
			region_on_reg <= 1'b0;
			disp_row_reg <= '0;
		end else begin
			if (LINE_START_IN) begin
				if (row_open) begin
					region_on_reg <= 1'b1;  // [RULE_07]
					disp_row_reg <= '0;
					total_left_reg <= field_pixel_total;  // [RULE_14]
				end else if (region_last_line) begin
					region_on_reg <= 1'b0;  // [RULE_08]
				end else if (region_on_reg) begin
					disp_row_reg <= disp_row_reg + osdw_pkg::ONE_12;
				end
			end else if (PIX_EN_IN && in_window) begin
				total_left_reg <= total_left_reg - 22'h000001;
			end
		end
	end

	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			valid_reg <= 1'b0;
			colour_reg <= '0;
			blend_reg <= osdw_pkg::BLEND_PIXEL;
			flicker_reg <= 1'b0;
			flutter_reg <= 1'b0;
			edge_reg <= 1'b0;
		end else if (PIX_EN_IN) begin
			if (in_window && !LINE_START_IN && !FIELD_START_IN) begin
				valid_reg <= 1'b1;
				colour_reg <= clut_mem[pix_byte];  // [RULE_21]
				blend_reg <= blend_select;  // [RULE_20] [RULE_24]
				flicker_reg <= (vfilter_select == osdw_pkg::FILT_FLICKER);  // [RULE_22] [RULE_25]
				flutter_reg <= (vfilter_select == osdw_pkg::FILT_FLUTTER);  // [RULE_22] [RULE_25]
				edge_reg <= !edge_smooth_disable && edge_row;  // [RULE_23]
			end else begin
				valid_reg <= 1'b0;  // [RULE_28]
				colour_reg <= '0;
				blend_reg <= osdw_pkg::BLEND_PIXEL;
				flicker_reg <= 1'b0;
				flutter_reg <= 1'b0;
				edge_reg <= 1'b0;
			end
		end
	end

	assign OSD_VALID_OUT = valid_reg;
	assign OSD_COLOUR_OUT = colour_reg;
	assign BLEND_SELECT_OUT = blend_reg;
	assign FLICKER_ON_OUT = flicker_reg;
	assign FLUTTER_ON_OUT = flutter_reg;
	assign EDGE_SMOOTH_ON_OUT = edge_reg;
	assign EDGE_SMOOTH_VALUE_OUT = edge_smooth_value;  // [RULE_23]

endmodule

`default_nettype wire

// file: verification/osdw_mem_model.sv
// Behavioural SDRAM controller model answering the walker's word reads
`timescale 1ns/1ps
`default_nettype none
module osdw_mem_model (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic req_in,
	input wire logic [31:0] addr_in,
	input wire logic [3:0] delay_in,
	output logic ack_out,
	output logic [31:0] rdata_out
);
	logic [31:0] mem [logic [31:0]];
	logic [3:0] wait_reg;

	////////////////////////////////////////
	// Ack after a programmable wait; data scrambled outside the ack cycle
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ack_out <= 1'b0;
			wait_reg <= 4'h0;
			rdata_out <= 32'h0;
		end else if (req_in && !ack_out && wait_reg >= delay_in) begin
			ack_out <= 1'b1;
			wait_reg <= 4'h0;
			rdata_out <= mem.exists(addr_in) ? mem[addr_in] : ~addr_in;
		end else begin
			ack_out <= 1'b0;
			wait_reg <= (req_in && !ack_out) ? wait_reg + 4'h1 : 4'h0;
			rdata_out <= ~rdata_out;
		end
	end
endmodule
`default_nettype wire

// file: verification/osdw_walker_monitor.sv
// Port-level assertions for the OSD region walker
`timescale 1ns/1ps
`default_nettype none
module osdw_walker_monitor (
	input wire logic CLK_IN,
	input wire logic ARST_N_IN,
	input wire logic [7:0] ADDR_IN,
	input wire logic [31:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic MEM_REQ_OUT,
	input wire logic [31:0] MEM_ADDR_OUT,
	input wire logic MEM_ACK_IN,
	input wire logic FIELD_START_IN,
	input wire logic PIX_EN_IN,
	input wire logic OSD_VALID_OUT,
	input wire logic [31:0] OSD_COLOUR_OUT,
	input wire logic [1:0] BLEND_SELECT_OUT,
	input wire logic FLICKER_ON_OUT,
	input wire logic FLUTTER_ON_OUT,
	input wire logic EDGE_SMOOTH_ON_OUT,
	input wire logic [7:0] EDGE_SMOOTH_VALUE_OUT
);
	logic [31:0] cfg_reg;
	logic [31:0] fsa_reg;

	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!ARST_N_IN);

	////////////////////////////////////////
	// Shadow copies of config and first-spec address
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			cfg_reg <= osdw_pkg::CFG_RESET;
			fsa_reg <= osdw_pkg::FSA_RESET;
		end else if (WR_IN && ADDR_IN == osdw_pkg::CFG_OFS) begin
			cfg_reg <= WDATA_IN;
		end else if (WR_IN && ADDR_IN == osdw_pkg::FSA_OFS) begin
			fsa_reg <= WDATA_IN;
		end
	end

	////////////////////////////////////////
	filter_exclusive_a: assert property (!(FLICKER_ON_OUT && FLUTTER_ON_OUT))
		else $error("both vertical filters on");
	idle_no_colour_a: assert property (!OSD_VALID_OUT |-> OSD_COLOUR_OUT == 32'h0 && BLEND_SELECT_OUT == 2'h0)
		else $error("colour or blend outside region");
	pixel_hold_a: assert property (!$past(PIX_EN_IN) |-> $stable(OSD_VALID_OUT) && $stable(OSD_COLOUR_OUT))
		else $error("pixel output moved without enable");
	edge_in_region_a: assert property (EDGE_SMOOTH_ON_OUT |-> OSD_VALID_OUT)
		else $error("smoothing outside region");
	smooth_off_a: assert property ($past(PIX_EN_IN) && $past(cfg_reg[osdw_pkg::CFG_SMOOTH_OFF_BIT])
		|-> !EDGE_SMOOTH_ON_OUT)
		else $error("smoothing while disabled");
	off_no_overlay_a: assert property ($past(PIX_EN_IN) && !$past(cfg_reg[osdw_pkg::CFG_ON_BIT])
		|-> !OSD_VALID_OUT)
		else $error("overlay while switched off");
	smooth_value_a: assert property (!WR_IN && !$past(WR_IN)
		|-> EDGE_SMOOTH_VALUE_OUT == cfg_reg[osdw_pkg::CFG_SMOOTH_LSB +: 8])
		else $error("smoothing value differs from config");
	fetch_hold_a: assert property (MEM_REQ_OUT && !MEM_ACK_IN && !FIELD_START_IN
		|=> MEM_REQ_OUT && $stable(MEM_ADDR_OUT))
		else $error("request dropped or moved before ack");
	walk_start_a: assert property (FIELD_START_IN && cfg_reg[osdw_pkg::CFG_ON_BIT]
		|=> MEM_REQ_OUT && MEM_ADDR_OUT == $past(fsa_reg))
		else $error("walk did not start at first spec");
endmodule

bind osdw_walker osdw_walker_monitor mon_i (
	.CLK_IN, .ARST_N_IN, .ADDR_IN, .WDATA_IN, .WR_IN, .MEM_REQ_OUT, .MEM_ADDR_OUT, .MEM_ACK_IN,
	.FIELD_START_IN, .PIX_EN_IN, .OSD_VALID_OUT, .OSD_COLOUR_OUT, .BLEND_SELECT_OUT, .FLICKER_ON_OUT,
	.FLUTTER_ON_OUT, .EDGE_SMOOTH_ON_OUT, .EDGE_SMOOTH_VALUE_OUT
);
`default_nettype wire

// file: verification/osd_region_descriptor_walker_tb.sv
// Self-checking bench for the OSD region walker
`timescale 1ns/1ps
`default_nettype none
module osd_region_descriptor_walker_tb;
	localparam logic [31:0] COL0 = 32'h00a0_b0c0;
	localparam logic [31:0] COL1 = 32'h00d0_e0f0;
	logic clk, arst_n, wr, rd, mem_req, mem_ack, field_start, field_bottom, line_start, pix_en;
	logic osd_valid, flicker_on, flutter_on, edge_on;
	logic [7:0] addr, edge_val;
	logic [11:0] line_num, pixel_x;
	logic [1:0] blend_sel;
	logic [3:0] mem_delay;
	logic [31:0] wdata, rdata, mem_addr, mem_rdata, osd_colour, rd_val;
	logic [31:0] got_q [$];
	int n_fail, tests_run, cycles;

	osdw_walker dut (.CLK_IN(clk), .ARST_N_IN(arst_n), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
		.RD_IN(rd), .RDATA_OUT(rdata), .MEM_REQ_OUT(mem_req), .MEM_ADDR_OUT(mem_addr), .MEM_ACK_IN(mem_ack),
		.MEM_RDATA_IN(mem_rdata), .FIELD_START_IN(field_start), .FIELD_BOTTOM_IN(field_bottom),
		.LINE_START_IN(line_start), .LINE_NUM_IN(line_num), .PIX_EN_IN(pix_en), .PIXEL_X_IN(pixel_x),
		.OSD_VALID_OUT(osd_valid), .OSD_COLOUR_OUT(osd_colour), .BLEND_SELECT_OUT(blend_sel),
		.FLICKER_ON_OUT(flicker_on), .FLUTTER_ON_OUT(flutter_on), .EDGE_SMOOTH_ON_OUT(edge_on),
		.EDGE_SMOOTH_VALUE_OUT(edge_val));
	osdw_mem_model mem_i (.clk_in(clk), .arst_n_in(arst_n), .req_in(mem_req), .addr_in(mem_addr),
		.delay_in(mem_delay), .ack_out(mem_ack), .rdata_out(mem_rdata));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Fetch log and hang guard
	always @(posedge clk) begin
		cycles++;
		if (mem_ack && mem_req) got_q.push_back(mem_addr);
		if (cycles == 20000) begin
			n_fail++;
			results();
		end
	end

	////////////////////////////////////////
	task automatic results();
		$display("Checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		rd_val = rdata;
	endtask

	task automatic pix(input logic [11:0] x, input logic [5:0] ef, input logic [31:0] ec);
		@(posedge clk);
		pix_en <= 1'b1;
		pixel_x <= x;
		@(posedge clk);
		pix_en <= 1'b0;
		@(negedge clk);
		chk("pixel flags", {26'h0, ef}, {26'h0, osd_valid, blend_sel, flicker_on, flutter_on, edge_on});
		chk("pixel colour", ec, osd_colour);
	endtask

	task automatic line(input logic [11:0] n);
		got_q.delete();
		@(posedge clk);
		line_start <= 1'b1;
		line_num <= n;
		@(posedge clk);
		line_start <= 1'b0;
		repeat (100) @(posedge clk);
	endtask

	task automatic field(input logic bot);
		got_q.delete();
		@(posedge clk);
		field_start <= 1'b1;
		field_bottom <= bot;
		@(posedge clk);
		field_start <= 1'b0;
		repeat (120) @(posedge clk);
	endtask

	task automatic hdr(input logic [31:0] a, input logic [31:0] w [9]);
		for (int i = 0; i < 9; i++) mem_i.mem[a + 32'(4 * i)] = w[i];
	endtask

	task automatic seq(input logic [31:0] base, input int n, input int ofs);
		for (int i = 0; i < n; i++) chk("fetch address", base + 32'(4 * i), got_q[ofs + i]);
	endtask

	// One interlaced field: region A on lines 5..7, region B on line 10
	task automatic run_int(input logic bot);
		mem_delay = bot ? 4'h0 : 4'h6;
		field(bot);
		chk("fetch count", 32'd11, 32'(got_q.size()));
		seq(32'h100, 9, 0);
		seq(32'h304, 2, 9);
		line(12'd4);
		pix(12'd20, 6'h00, 32'h0);
		chk("row 0 address", 32'h400, got_q[0]);
		line(12'd5);
		chk("row 1 address", 32'h408, got_q[0]);
		pix(12'd20, 6'h35, COL0);
		pix(12'd22, 6'h35, COL1);
		pix(12'd23, 6'h00, 32'h0);
		pix(12'd19, 6'h00, 32'h0);
		line(12'd6);
		pix(12'd20, 6'h34, COL1);
		line(12'd7);
		pix(12'd20, 6'h35, COL0);
		line(12'd8);
		chk("header count", 32'd9, 32'(got_q.size()));
		seq(32'h200, 9, 0);
		pix(12'd20, 6'h00, 32'h0);
		line(12'd9);
		chk("row address", bot ? 32'h500 : 32'h600, got_q[0]);
		line(12'd10);
		pix(12'd20, 6'h3b, bot ? COL1 : COL0);
		pix(12'd22, 6'h00, 32'h0);
		line(12'd11);
		pix(12'd20, 6'h00, 32'h0);
		line(12'd12);
		chk("fetches after end", 32'd0, 32'(got_q.size()));
		rd_reg(osdw_pkg::STAT_OFS);
		chk("list done", 32'h2, rd_val & 32'h2);
		$display("Test interlaced field %0d done", bot);
	endtask

	////////////////////////////////////////
	initial begin
		arst_n = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		field_start = 1'b0;
		field_bottom = 1'b0;
		line_start = 1'b0;
		line_num = 12'h000;
		pix_en = 1'b0;
		pixel_x = 12'h000;
		mem_delay = 4'h6;
		n_fail = 0;
		tests_run = 0;
		cycles = 0;
		for (int i = 0; i < 6; i++) mem_i.mem[32'h400 + 32'(8 * i)] = 32'h0000_0010;
		mem_i.mem[32'h400] = 32'h1011_1110;
		mem_i.mem[32'h408] = 32'h0000_0011;
		mem_i.mem[32'h500] = 32'h0000_0011;
		mem_i.mem[32'h600] = 32'h0000_0010;
		mem_i.mem[32'h304] = COL0;
		mem_i.mem[32'h308] = COL1;
		hdr(32'h100, '{32'h0004_0049, 32'h0008_0110, 32'h0000_0100, 32'h0000_8014, 32'h0000_5017,
			32'h400, 32'h400, 32'h304, 32'h200});
		hdr(32'h200, '{32'h0002_0072, 32'h0008_0533, 32'h0000_0100, 32'h0000_b014, 32'h0000_a028,
			32'h500, 32'h600, 32'h700, 32'h0});
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		rd_reg(osdw_pkg::CFG_OFS);
		chk("config reset", osdw_pkg::CFG_RESET, rd_val);
		rd_reg(osdw_pkg::FSA_OFS);
		chk("first spec reset", osdw_pkg::FSA_RESET, rd_val);
		wr_reg(8'h0c, 32'hffff_ffff);
		rd_reg(8'h0c);
		chk("unmapped read", 32'h0, rd_val);
		wr_reg(osdw_pkg::FSA_OFS, 32'h0000_0100);
		wr_reg(osdw_pkg::CFG_OFS, 32'h0000_5501);
		rd_reg(osdw_pkg::CFG_OFS);
		chk("config", 32'h0000_5501, rd_val);
		$display("Test registers done");
		run_int(1'b0);
		run_int(1'b1);
		// Progressive: lines doubled, smoothing off, remaining codes
		wr_reg(osdw_pkg::CFG_OFS, 32'h0000_5507);
		mem_i.mem[32'h100] = 32'h0004_0001;
		mem_i.mem[32'h200] = 32'h0002_003a;
		mem_delay <= 4'h3;
		field(1'b0);
		for (int n = 9; n < 21; n++) begin
			line(12'(n));
			if (n == 10 || n == 15) pix(12'd20, 6'h20, COL0);
			if (n == 16) pix(12'd20, 6'h00, 32'h0);
		end
		pix(12'd20, 6'h28, COL0);
		chk("smoothing value", 32'h55, {24'h0, edge_val});
		wr_reg(osdw_pkg::CFG_OFS, 32'h0000_5506);
		pix(12'd20, 6'h00, 32'h0);
		$display("Test progressive field done");
		results();
	end
endmodule
`default_nettype wire
